// ### verilog/i2srp_consts.vh
// Purpose: constants for the two-wire slave register port
// Assumes: included by bare name from the design files
// Notes:   timing counts are in system clock cycles at 50 MHz
`ifndef I2SRP_CONSTS_VH
`define I2SRP_CONSTS_VH

`define I2SRP_ADDR_PREFIX   5'h0a
`define I2SRP_RW_WRITE      1'b0
`define I2SRP_RW_READ       1'b1
`define I2SRP_FIFO_ADDR_RST 8'h05
`define I2SRP_FIFO_DEPTH    8
`define I2SRP_FIFO_AW       3
`define I2SRP_PTR_RST       8'h00
`define I2SRP_BITS_PER_BYTE 4'h8

`endif

// ### verilog/i2srp_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   read data comes from a register; depth must be a power of two
`timescale 1ns/100ps
module i2srp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             arst_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    reg [WIDTH-1:0] out_data_r;
    reg             out_valid_r;
    wire            push;
    wire            pop;
    wire            load;

    // output register counts as one of the DEPTH slots
    assign in_ready_o  = (count_r + {{AW{1'b0}}, out_valid_r} != DEPTH[AW:0]);
    assign push        = in_valid_i && in_ready_o;
    assign load        = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready_i);
    assign pop         = load;
    assign out_valid_o = out_valid_r;
    assign out_data_o  = out_data_r;

    always @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_r    <= {AW{1'b0}};
            rd_ptr_r    <= {AW{1'b0}};
            count_r     <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
            out_data_r  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_r   <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
                out_data_r <= mem_r[rd_ptr_r];
            end
            if (push && !pop) begin
                count_r <= count_r + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_r <= count_r - {{AW{1'b0}}, 1'b1};
            end
            if (load) begin
                out_valid_r <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule // i2srp_fifo

// ### verilog/i2srp_slave.v
// Purpose: two-wire slave port giving a host access to registers and a fifo
// Assumes: scl/sda pins are sampled by clk_i; master drives scl push-pull
// Notes:   register storage lives outside; this port issues read/write strobes
// Notes on behaviour
// [R1] data line changes only while clock low; held while clock high
// [R2] data falling while clock high is a start condition
// [R3] data rising while clock high is a stop condition ending the transfer
// [R4] only the master makes start and stop; repeated start keeps bus busy
// [R5] repeated start restarts address decoding with no stop needed
// [R6] bytes go msb first, each followed by an acknowledge bit
// [R7] any number of bytes accepted within one frame
// [R8] transmitter releases data on ack; receiver holds it low through high phase
// [R9] master nack ends a read; slave then releases the data line
// [R10] first byte after start selects; 5 fixed bits plus 2 configurable bits
// [R11] write: address with direction 0, register address, then data bytes
// [R12] write to fifo address puts every data byte in the fifo, no increment; here a byte arriving while the fifo is full is dropped and nacked
// [R13] master sets the pointer with a write frame before reading
// [R14] read: address with direction 1, device returns addressed register bytes
// [R15] multi-byte read advances the pointer after each byte
// [R16] read pointer at fifo address stays constant
// [R17] point-to-point variant uses same framing, clock 0 to 5 MHz
// [R18] master drives clock push-pull; device never stretches clock
// [R19] point-to-point data line has a keeper holding its last level
// [R20] pin-set address forces the higher low bit to 0
// [R21] master drives data high while the link is idle
// [R22] on point-to-point, drivers change data only while clock low
// [R23] no clock stretch, no general call, no device id, slave only
// [R24] mismatched address is not acknowledged; idle until next start
`timescale 1ns/100ps
`include "i2srp_consts.vh"
module i2srp_slave #(
    parameter [7:0] FIFO_ADDR = `I2SRP_FIFO_ADDR_RST
) (
    input  wire       clk_i,
    input  wire       arst_n_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe_n_o,
    input  wire       p2p_mode_i,
    input  wire       addr_by_pin_i,
    input  wire [1:0] addr_pins_i,
    input  wire [1:0] addr_cfg_i,
    output reg        reg_wr_o,
    output reg        reg_rd_o,
    output reg  [7:0] reg_addr_o,
    output reg  [7:0] reg_wdata_o,
    input  wire [7:0] reg_rdata_i,
    output reg        busy_o,
    output reg        fifo_in_ready_o,
    output reg        fifo_out_valid_o,
    output reg  [7:0] fifo_out_data_o,
    input  wire       fifo_out_ready_i,
    input  wire       fifo_rd_valid_i,
    input  wire [7:0] fifo_rd_data_i,
    output reg        fifo_rd_pop_o,
    output reg        keeper_level_o
);
    // ************************************************************
    // states
    // ************************************************************
    localparam ST_IDLE  = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_AACK  = 3'h2;
    localparam ST_WBYTE = 3'h3;
    localparam ST_WACK  = 3'h4;
    localparam ST_RBYTE = 3'h5;
    localparam ST_RACK  = 3'h6;

    // ************************************************************
    // pin sampling: three flops, change accepted when 2nd and 3rd agree
    // ************************************************************
    reg  [2:0] scl_sync_r;
    reg  [2:0] sda_sync_r;
    reg        scl_r;
    reg        sda_r;
    reg        scl_nxt;
    reg        sda_nxt;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
            scl_r      <= 1'b1;
            sda_r      <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], scl_i};
            sda_sync_r <= {sda_sync_r[1:0], sda_i};
            scl_r      <= scl_nxt;
            sda_r      <= sda_nxt;
        end
    end

    always @* begin
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        if (scl_sync_r[1] == scl_sync_r[2]) begin
            scl_nxt = scl_sync_r[2];
        end
        if (sda_sync_r[1] == sda_sync_r[2]) begin
            sda_nxt = sda_sync_r[2];
        end
    end

    assign scl_rise  = !scl_r && scl_nxt;
    assign scl_fall  = scl_r && !scl_nxt;
    // sda moving while scl stays high marks the frame boundaries
    assign start_det = scl_r && scl_nxt && sda_r && !sda_nxt; // [R2]
    assign stop_det  = scl_r && scl_nxt && !sda_r && sda_nxt; // [R3]

    // ************************************************************
    // fifo on the write path
    // ************************************************************
    reg        fifo_push_r;
    reg  [7:0] fifo_push_data_r;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;

    i2srp_fifo #(
        .WIDTH (8),
        .DEPTH (`I2SRP_FIFO_DEPTH),
        .AW    (`I2SRP_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (fifo_push_r),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_push_data_r),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready_i),
        .out_data_o  (fifo_out_data)
    );

    // ************************************************************
    // protocol engine
    // ************************************************************
    reg  [2:0] state_r;
    reg  [3:0] bit_cnt_r;
    reg  [7:0] shift_r;
    reg  [7:0] ptr_r;
    reg        ptr_set_r;
    reg        rd_dir_r;
    reg        ack_ok_r;
    wire [6:0] my_addr;
    wire [1:0] low_bits;
    wire       at_fifo;

    assign low_bits = addr_by_pin_i ? {1'b0, addr_pins_i[0]} : addr_cfg_i; // [R20]
    assign my_addr  = {`I2SRP_ADDR_PREFIX, low_bits}; // [R10]
    assign at_fifo  = (ptr_r == FIFO_ADDR);

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r          <= ST_IDLE;
            bit_cnt_r        <= 4'h0;
            shift_r          <= 8'h00;
            ptr_r            <= `I2SRP_PTR_RST;
            ptr_set_r        <= 1'b0;
            rd_dir_r         <= 1'b0;
            ack_ok_r         <= 1'b0;
            sda_o            <= 1'b1;
            sda_oe_n_o       <= 1'b1;
            reg_wr_o         <= 1'b0;
            reg_rd_o         <= 1'b0;
            reg_addr_o       <= 8'h00;
            reg_wdata_o      <= 8'h00;
            busy_o           <= 1'b0;
            fifo_push_r      <= 1'b0;
            fifo_push_data_r <= 8'h00;
            fifo_rd_pop_o    <= 1'b0;
        end else begin
            reg_wr_o      <= 1'b0;
            reg_rd_o      <= 1'b0;
            fifo_rd_pop_o <= 1'b0;
            if (fifo_push_r && fifo_in_ready) begin
                fifo_push_r <= 1'b0;
            end
            if (start_det) begin
                // repeated start behaves exactly as a first start
                state_r    <= ST_ADDR; // [R5]
                bit_cnt_r  <= 4'h0;
                busy_o     <= 1'b1; // [R4]
                sda_oe_n_o <= 1'b1;
            end else if (stop_det) begin
                state_r    <= ST_IDLE;
                busy_o     <= 1'b0; // [R3]
                sda_oe_n_o <= 1'b1;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        sda_oe_n_o <= 1'b1; // [R24]
                    end
                    ST_ADDR, ST_WBYTE: begin
                        if (scl_rise) begin
                            shift_r   <= {shift_r[6:0], sda_r}; // [R6]
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == `I2SRP_BITS_PER_BYTE) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == ST_ADDR) begin
                                // general call and foreign addresses get no ack
                                if (shift_r[7:1] == my_addr) begin // [R23]
                                    rd_dir_r   <= shift_r[0]; // [R14]
                                    ptr_set_r  <= 1'b0;
                                    sda_o      <= 1'b0;
                                    sda_oe_n_o <= 1'b0; // [R8]
                                    state_r    <= ST_AACK;
                                    if (shift_r[0] == `I2SRP_RW_READ) begin
                                        reg_addr_o <= ptr_r;
                                        reg_rd_o   <= !at_fifo;
                                    end
                                end else begin
                                    state_r <= ST_IDLE; // [R24]
                                end
                            end else begin
                                ack_ok_r <= 1'b1;
                                if (!ptr_set_r) begin
                                    ptr_r     <= shift_r; // [R11]
                                    ptr_set_r <= 1'b1; // [R13]
                                end else begin
                                    if (at_fifo) begin
                                        // fifo full: nack rather than stretch scl
                                        ack_ok_r         <= fifo_in_ready && !fifo_push_r;
                                        fifo_push_r      <= fifo_in_ready && !fifo_push_r;
                                        fifo_push_data_r <= shift_r; // [R12]
                                    end else begin
                                        reg_wr_o    <= 1'b1;
                                        reg_addr_o  <= ptr_r;
                                        reg_wdata_o <= shift_r;
                                        ptr_r       <= ptr_r + 8'h01; // [R7]
                                    end
                                end
                                sda_o      <= 1'b0;
                                sda_oe_n_o <= 1'b0; // [R8]
                                state_r    <= ST_WACK;
                            end
                        end
                    end
                    ST_AACK, ST_WACK: begin
                        if (state_r == ST_WACK && !ack_ok_r) begin
                            sda_oe_n_o <= 1'b1;
                            sda_o      <= 1'b1;
                        end
                        // drive changes on the falling clock edge; a fifo nack releases one clock after the ack edge
                        if (scl_fall) begin // [R22]
                            if (rd_dir_r && state_r == ST_AACK) begin
                                if (at_fifo) begin
                                    sda_o         <= fifo_rd_data_i[7];
                                    shift_r       <= fifo_rd_valid_i ? fifo_rd_data_i : 8'h00;
                                    fifo_rd_pop_o <= fifo_rd_valid_i; // [R16]
                                end else begin
                                    sda_o   <= reg_rdata_i[7];
                                    shift_r <= reg_rdata_i;
                                end
                                sda_oe_n_o <= 1'b0;
                                bit_cnt_r  <= 4'h1;
                                state_r    <= ST_RBYTE;
                            end else begin
                                sda_oe_n_o <= 1'b1; // [R1]
                                sda_o      <= 1'b1;
                                bit_cnt_r  <= 4'h0;
                                state_r    <= ST_WBYTE;
                            end
                        end
                    end
                    ST_RBYTE: begin
                        if (scl_fall) begin // [R1]
                            if (bit_cnt_r == `I2SRP_BITS_PER_BYTE) begin
                                sda_oe_n_o <= 1'b1; // [R8]
                                sda_o      <= 1'b1;
                                state_r    <= ST_RACK;
                                if (!at_fifo) begin
                                    ptr_r <= ptr_r + 8'h01; // [R15]
                                end
                            end else begin
                                sda_o     <= shift_r[7 - bit_cnt_r[2:0]]; // [R6]
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_r) begin
                                state_r <= ST_IDLE; // [R9]
                            end else begin
                                reg_addr_o <= ptr_r;
                                reg_rd_o   <= !at_fifo;
                            end
                        end else if (scl_fall) begin
                            if (at_fifo) begin
                                sda_o         <= fifo_rd_data_i[7];
                                shift_r       <= fifo_rd_valid_i ? fifo_rd_data_i : 8'h00;
                                fifo_rd_pop_o <= fifo_rd_valid_i; // [R16]
                            end else begin
                                sda_o   <= reg_rdata_i[7];
                                shift_r <= reg_rdata_i;
                            end
                            sda_oe_n_o <= 1'b0;
                            bit_cnt_r  <= 4'h1;
                            state_r    <= ST_RBYTE;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // keeper and fifo outputs
    // ************************************************************
    // keeper takes the slave's own drive while enabled, else follows the filtered line, holding it while nobody drives
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            keeper_level_o   <= 1'b1;
            fifo_in_ready_o  <= 1'b0;
            fifo_out_valid_o <= 1'b0;
            fifo_out_data_o  <= 8'h00;
        end else begin
            keeper_level_o   <= (!sda_oe_n_o) ? sda_o : sda_r; // [R19]
            fifo_in_ready_o  <= fifo_in_ready;
            fifo_out_valid_o <= fifo_out_valid;
            fifo_out_data_o  <= fifo_out_data;
        end
    end

    // p2p mode changes no framing; the master clocks at up to 5 MHz
    wire unused_mode = p2p_mode_i; // [R17]
endmodule // i2srp_slave

// ### verification/i2srp_props.sv
// Purpose: temporal checks on the slave port pins and strobes
// Assumes: bound to i2srp_slave, pins seen raw at its inputs, not through its sync flops
// Notes:   pin qualifiers use scl high for 3 clocks, so late device edges are not conditions
`timescale 1ns/100ps
module i2srp_props #(
    parameter [7:0] FIFO_ADDR = 8'h05
) (
    input wire       clk_i,
    input wire       arst_n_i,
    input wire       scl_i,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe_n_o,
    input wire       reg_wr_o,
    input wire       reg_rd_o,
    input wire [7:0] reg_addr_o,
    input wire       busy_o,
    input wire       fifo_rd_pop_o,
    input wire       keeper_level_o
);
    // ****************************************
    // read pointer history within one busy span
    // ****************************************
    reg       rd_seen_r;
    reg [7:0] rd_prev_r;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_seen_r <= 1'b0;
            rd_prev_r <= 8'h00;
        end else if (!busy_o) begin
            rd_seen_r <= 1'b0;
        end else if (reg_rd_o) begin
            rd_seen_r <= 1'b1;
            rd_prev_r <= reg_addr_o;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_start;
        $fell(sda_i) && scl_i && $past(scl_i, 3) |-> ##[1:8] busy_o;
    endproperty
    a_start: assert property (p_start) else $error("start not seen");
    property p_stop;
        $rose(sda_i) && scl_i && $past(scl_i, 3) |-> ##[1:8] !busy_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not seen");
    property p_idle_released;
        !busy_o |-> sda_oe_n_o;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("drive outside frame");
    property p_keeper;
        $stable(sda_i) [*7] |-> keeper_level_o == sda_i;
    endproperty
    a_keeper: assert property (p_keeper) else $error("keeper lost level");
    property p_wr_ack;
        reg_wr_o && reg_addr_o != FIFO_ADDR |-> ##[0:2] (!sda_oe_n_o && !sda_o);
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write without ack");
    property p_pop_at_fifo;
        fifo_rd_pop_o |-> reg_addr_o == FIFO_ADDR;
    endproperty
    a_pop_at_fifo: assert property (p_pop_at_fifo) else $error("pop off fifo address");
    property p_advance;
        reg_rd_o && rd_seen_r && rd_prev_r != FIFO_ADDR |-> reg_addr_o == rd_prev_r + 8'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("pointer not advanced");
    property p_pop_pulse;
        fifo_rd_pop_o |=> !fifo_rd_pop_o;
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) else $error("pop too long");
endmodule // i2srp_props

bind i2srp_slave i2srp_props #(.FIFO_ADDR(FIFO_ADDR)) i2srp_props_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_addr_o(reg_addr_o), .busy_o(busy_o), .fifo_rd_pop_o(fifo_rd_pop_o),
    .keeper_level_o(keeper_level_o));

// ### verification/i2srp_host_model.sv
// Purpose: bus master model driving clock push-pull and data with release
// Assumes: 160 ns bus clock; 5 clocks low so filtered slave drive lands before rise, 3 high
// Notes:   clock stands high between frames; data driven high when idle
`timescale 1ns/100ps
module i2srp_host_model (
    input  wire clk_i,
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_o,
    output reg  sda_en_o
);
    // ****************************************
    // bus primitives
    // ****************************************
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        sda_en_o = 1'b1;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // data moves early in the low phase, sampled at the end of high
    task bit_io(input d, input drv, output s);
        begin
            tick(1);
            sda_en_o <= drv;
            sda_o    <= d;
            tick(4);
            scl_o    <= 1'b1;
            tick(3);
            s = sda_i;
            scl_o    <= 1'b0;
        end
    endtask
    task start;
        begin
            tick(1);
            sda_en_o <= 1'b1;
            sda_o    <= 1'b1;
            tick(4);
            scl_o    <= 1'b1;
            tick(4);
            sda_o    <= 1'b0;
            tick(4);
            scl_o    <= 1'b0;
        end
    endtask
    task stop;
        begin
            tick(1);
            sda_en_o <= 1'b1;
            sda_o    <= 1'b0;
            tick(3);
            scl_o    <= 1'b1;
            tick(4);
            sda_o    <= 1'b1;
            tick(4);
        end
    endtask
    task wr_byte(input [7:0] d, output ack);
        integer i;
        reg     s;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_io(d[i], 1'b1, s);
            bit_io(1'b1, 1'b0, s);
            ack = !s;
        end
    endtask
    task rd_byte(output [7:0] d, input ack);
        integer i;
        reg     s;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                bit_io(1'b1, 1'b0, s);
                d = {d[6:0], s};
            end
            bit_io(1'b0, ack, s);
        end
    endtask
endmodule // i2srp_host_model

// ### verification/i2c_slave_register_port_tb.sv
// Purpose: self-checking bench for the two-wire slave register port
// Assumes: pull-up on data, register file and read fifo modelled here
// Notes:   device address 0x2b from config bits, 0x29 from pins
`timescale 1ns/100ps
module i2c_slave_register_port_tb;
    reg        clk_i = 1'b0;
    reg        arst_n_r = 1'b0;
    reg        by_pin_r = 1'b0;
    reg  [1:0] pins_r = 2'b11;
    reg  [1:0] cfg_r = 2'b11;
    reg        out_rdy_r = 1'b0;
    reg  [7:0] rd_idx_r = 8'h00;
    reg  [7:0] regs_r [0:255];
    wire       scl, m_sda, m_en, s_sda, s_oe_n, sda, reg_wr, reg_rd, in_rdy, out_valid, pop;
    wire [7:0] reg_addr, wdata, out_data;
    integer    fail_count = 0;
    integer    samples_checked = 0;
    reg        ack;
    reg  [7:0] b;
    // ****************************************
    // wiring and far-side models
    // ****************************************
    assign sda = !s_oe_n ? s_sda : (m_en ? m_sda : 1'b1);
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (reg_wr) regs_r[reg_addr] <= wdata;
        if (pop) rd_idx_r <= rd_idx_r + 8'h01;
    end
    i2srp_host_model host_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda),
        .sda_en_o(m_en));
    i2srp_slave #(.FIFO_ADDR(8'h05)) i2srp_slave_inst (
        .clk_i(clk_i), .arst_n_i(arst_n_r), .scl_i(scl), .sda_i(sda), .sda_o(s_sda),
        .sda_oe_n_o(s_oe_n), .p2p_mode_i(1'b0), .addr_by_pin_i(by_pin_r),
        .addr_pins_i(pins_r), .addr_cfg_i(cfg_r), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(wdata), .reg_rdata_i(regs_r[reg_addr]),
        .busy_o(), .fifo_in_ready_o(in_rdy), .fifo_out_valid_o(out_valid),
        .fifo_out_data_o(out_data), .fifo_out_ready_i(out_rdy_r), .fifo_rd_valid_i(1'b1),
        .fifo_rd_data_i(8'hc0 + rd_idx_r), .fifo_rd_pop_o(pop), .keeper_level_o());
    // ****************************************
    // scenarios
    // ****************************************
    task check(input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task addr(input [6:0] a, input rw, input exp_ack);
        begin
            host_inst.start;
            host_inst.wr_byte({a, rw}, ack);
            check({7'h00, ack}, {7'h00, exp_ack});
        end
    endtask
    task t_write_read;
        integer i;
        begin
            addr(7'h2b, 1'b0, 1'b1);
            host_inst.wr_byte(8'h10, ack);
            for (i = 0; i < 3; i = i + 1) begin
                host_inst.wr_byte(8'ha0 + i[7:0], ack);
                check({7'h00, ack}, 8'h01);
            end
            host_inst.stop;
            check(regs_r[8'h11], 8'ha1);
            addr(7'h2b, 1'b0, 1'b1);
            host_inst.wr_byte(8'h10, ack);
            host_inst.stop;
            addr(7'h2b, 1'b1, 1'b1);
            for (i = 0; i < 3; i = i + 1) begin
                host_inst.rd_byte(b, i < 2);
                check(b, 8'ha0 + i[7:0]);
            end
            host_inst.stop;
        end
    endtask
    task t_addr;
        begin
            addr(7'h00, 1'b0, 1'b0);
            addr(7'h2a, 1'b0, 1'b0);
            addr(7'h2b, 1'b0, 1'b1);
            host_inst.stop;
            by_pin_r <= 1'b1;
            addr(7'h29, 1'b0, 1'b1);
            addr(7'h2b, 1'b0, 1'b0);
            host_inst.stop;
            by_pin_r <= 1'b0;
        end
    endtask
    task t_fifo_fill;
        integer i;
        begin
            addr(7'h2b, 1'b0, 1'b1);
            host_inst.wr_byte(8'h05, ack);
            for (i = 0; i < 9; i = i + 1) begin
                host_inst.wr_byte(8'h50 + i[7:0], ack);
                check({7'h00, ack}, {7'h00, i < 8});
            end
            host_inst.stop;
            check({7'h00, in_rdy}, 8'h00);
            for (i = 0; i < 8; i = i + 1) begin
                check({7'h00, out_valid}, 8'h01);
                check(out_data, 8'h50 + i[7:0]);
                out_rdy_r <= 1'b1;
                @(posedge clk_i);
                out_rdy_r <= 1'b0;
                repeat (3) @(posedge clk_i);
            end
            check({7'h00, out_valid}, 8'h00);
        end
    endtask
    task t_fifo_read;
        integer i;
        begin
            addr(7'h2b, 1'b0, 1'b1);
            host_inst.wr_byte(8'h05, ack);
            addr(7'h2b, 1'b1, 1'b1);
            for (i = 0; i < 3; i = i + 1) begin
                host_inst.rd_byte(b, i < 2);
                check(b, 8'hc0 + i[7:0]);
            end
            host_inst.stop;
            check(reg_addr, 8'h05);
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d, mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_r <= 1'b1;
        repeat (6) @(posedge clk_i);
        t_write_read;
        t_addr;
        t_fifo_fill;
        t_fifo_read;
        print_verdict;
    end
    // whole run needs about 2650 clocks
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count = fail_count + 1;
        print_verdict;
    end
endmodule // i2c_slave_register_port_tb
